// File: logic/lrx_pkg.sv
// Constants and encodings for the literal-return / rotate / xor execution block
//
// Functional notes
// [RL1] Four user ID words at 2000h-2003h, reachable only in program/verify mode; writes and prog_hit_o are gated by mode, prog_rdata_o is not.
// [RL2] Each user ID word keeps only its low four bits.
// [RL3] 11 01xx kkkk kkkk loads the literal into the working register, flags unchanged.
// [RL4] Literal-return also pops the stack into the program counter; two cycles.
// [RL5] 00 1101 dfff ffff rotates file register left through carry; one cycle.
// [RL6] Rotate destination bit: 0 writes working register, 1 writes file register.
// [RL7] 00 0000 0000 1000 pops stack into program counter, no flags, two cycles.
// [RL8] 11 1010 kkkk kkkk xors literal into working register, zero flag only.
// [RL9] 00 0110 dfff ffff xors working and file register to chosen destination.
// [RL10] Zero flag is set when the 8-bit result is zero, else cleared.
package lrx_pkg;
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 14;
  localparam int UID_W = 4;
  localparam int UID_CNT = 4;
  localparam logic [PC_W-1:0] UID_BASE = 14'h2000;
  localparam logic [PC_W-1:0] UID_LAST = 14'h2003;
  localparam logic [3:0] LITRET_PAT = 4'hd;
  localparam logic [5:0] XORLIT_PAT = 6'h3a;
  localparam logic [5:0] ROT_PAT = 6'h0d;
  localparam logic [5:0] XORREG_PAT = 6'h06;
  localparam logic [INSN_W-1:0] RETURN_PAT = 14'h0008;
  localparam int DEST_BIT = 7;
  localparam int MSB = 7;
  typedef enum logic [2:0] {
    LRX_OP_NONE = 3'b000,
    LRX_OP_LITRET = 3'b001,
    LRX_OP_RET = 3'b010,
    LRX_OP_ROT = 3'b011,
    LRX_OP_XORLIT = 3'b100,
    LRX_OP_XORREG = 3'b101
  } lrx_op_t;
  typedef enum logic [0:0] {
    LRX_ST_EXEC = 1'b0,
    LRX_ST_DUMMY = 1'b1
  } lrx_state_t;
endpackage : lrx_pkg

// File: logic/lrx_uid_store.sv
// User identification word storage, low nibble only
`timescale 1ns/100ps
module lrx_uid_store
  import lrx_pkg::*;
#(
  parameter int COUNT = UID_CNT
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Access
  input wire logic wr_i,
  input wire logic [$clog2(COUNT)-1:0] idx_i,
  input wire logic [INSN_W-1:0] wdata_i,
  output logic [INSN_W-1:0] rdata_o
);
  logic [UID_W-1:0] mem_q [COUNT];

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < COUNT; i++) mem_q[i] <= '0;
    end else if (wr_i) begin
      mem_q[idx_i] <= wdata_i[UID_W-1:0]; // [RL2]
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= {{(INSN_W-UID_W){1'b0}}, mem_q[idx_i]}; // [RL2]
    end
  end
endmodule : lrx_uid_store

// File: logic/lrx_exec.sv
// Decoder and executor for literal-return, return, rotate and xor instructions
`timescale 1ns/100ps
module lrx_exec
  import lrx_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Instruction issue
  input wire logic insn_valid_i,
  input wire logic [INSN_W-1:0] insn_i,
  output logic busy_o,
  // Core state in
  input wire logic [DATA_W-1:0] wreg_i,
  input wire logic [DATA_W-1:0] freg_rdata_i,
  input wire logic carry_i,
  input wire logic [PC_W-1:0] stack_top_entry_i,
  // Core updates out
  output logic wreg_we_o,
  output logic [DATA_W-1:0] wreg_wdata_o,
  output logic freg_we_o,
  output logic [FADDR_W-1:0] freg_addr_o,
  output logic [DATA_W-1:0] freg_wdata_o,
  output logic carry_we_o,
  output logic carry_o,
  output logic zero_we_o,
  output logic zero_o,
  output logic pc_load_o,
  output logic [PC_W-1:0] pc_o,
  output logic stack_pop_o,
  // Program/verify access
  input wire logic prog_mode_i,
  input wire logic prog_wr_i,
  input wire logic [PC_W-1:0] prog_addr_i,
  input wire logic [INSN_W-1:0] prog_wdata_i,
  output logic [INSN_W-1:0] prog_rdata_o,
  output logic prog_hit_o
);
  function automatic lrx_op_t decode(input logic [INSN_W-1:0] insn);
    if (insn[INSN_W-1 -: $bits(LITRET_PAT)] == LITRET_PAT) decode = LRX_OP_LITRET; // [RL3]
    else if (insn == RETURN_PAT) decode = LRX_OP_RET; // [RL7]
    else if (insn[INSN_W-1 -: $bits(ROT_PAT)] == ROT_PAT) decode = LRX_OP_ROT; // [RL5]
    else if (insn[INSN_W-1 -: $bits(XORLIT_PAT)] == XORLIT_PAT) decode = LRX_OP_XORLIT; // [RL8]
    else if (insn[INSN_W-1 -: $bits(XORREG_PAT)] == XORREG_PAT) decode = LRX_OP_XORREG; // [RL9]
    else decode = LRX_OP_NONE;
  endfunction : decode

  function automatic logic is_uid(input logic [PC_W-1:0] a);
    is_uid = (a >= UID_BASE) && (a <= UID_LAST);
  endfunction : is_uid

  lrx_op_t op;
  lrx_state_t state_q;
  logic take;
  logic dest;
  logic [DATA_W-1:0] lit;
  logic [DATA_W-1:0] rot_res;
  logic [DATA_W-1:0] xr_res;
  logic uid_hit;
  logic [INSN_W-1:0] uid_rdata;

  assign take = insn_valid_i && (state_q == LRX_ST_EXEC);
  assign op = decode(insn_i);
  assign dest = insn_i[DEST_BIT];
  assign lit = insn_i[DATA_W-1:0];
  assign rot_res = {freg_rdata_i[MSB-1:0], carry_i}; // [RL5]
  assign xr_res = wreg_i ^ freg_rdata_i; // [RL9]
  assign uid_hit = prog_mode_i && is_uid(prog_addr_i); // [RL1]

  // Two-cycle control: second cycle is a dummy that refuses issue
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= LRX_ST_EXEC;
      busy_o <= 1'b0;
    end else begin
      case (state_q)
        LRX_ST_EXEC: begin
          if (take && (op == LRX_OP_LITRET || op == LRX_OP_RET)) begin
            state_q <= LRX_ST_DUMMY; // [RL4] [RL7]
            busy_o <= 1'b1;
          end
        end
        LRX_ST_DUMMY: begin
          state_q <= LRX_ST_EXEC;
          busy_o <= 1'b0;
        end
        default: begin
          state_q <= LRX_ST_EXEC;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  // Working register and file register writes
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wreg_we_o <= 1'b0;
      wreg_wdata_o <= '0;
      freg_we_o <= 1'b0;
      freg_addr_o <= '0;
      freg_wdata_o <= '0;
    end else begin
      wreg_we_o <= 1'b0;
      freg_we_o <= 1'b0;
      freg_addr_o <= insn_i[FADDR_W-1:0];
      if (take) begin
        case (op)
          LRX_OP_LITRET: begin
            wreg_we_o <= 1'b1; // [RL3]
            wreg_wdata_o <= lit;
          end
          LRX_OP_XORLIT: begin
            wreg_we_o <= 1'b1; // [RL8]
            wreg_wdata_o <= wreg_i ^ lit;
          end
          LRX_OP_ROT: begin
            wreg_we_o <= !dest; // [RL6]
            freg_we_o <= dest;
            wreg_wdata_o <= rot_res;
            freg_wdata_o <= rot_res;
          end
          LRX_OP_XORREG: begin
            wreg_we_o <= !dest; // [RL9]
            freg_we_o <= dest;
            wreg_wdata_o <= xr_res;
            freg_wdata_o <= xr_res;
          end
          default: begin
            wreg_we_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // Status flag updates
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      carry_we_o <= 1'b0;
      carry_o <= 1'b0;
      zero_we_o <= 1'b0;
      zero_o <= 1'b0;
    end else begin
      carry_we_o <= take && (op == LRX_OP_ROT); // [RL5]
      carry_o <= freg_rdata_i[MSB];
      zero_we_o <= take && (op == LRX_OP_XORLIT || op == LRX_OP_XORREG); // [RL8] [RL9]
      if (op == LRX_OP_XORLIT) zero_o <= ((wreg_i ^ lit) == '0); // [RL10]
      else zero_o <= (xr_res == '0); // [RL10]
    end
  end

  // Program counter reload from stack
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_load_o <= 1'b0;
      stack_pop_o <= 1'b0;
      pc_o <= '0;
    end else begin
      pc_load_o <= take && (op == LRX_OP_LITRET || op == LRX_OP_RET); // [RL4] [RL7]
      stack_pop_o <= take && (op == LRX_OP_LITRET || op == LRX_OP_RET);
      pc_o <= stack_top_entry_i;
    end
  end

  // User ID access in program/verify mode
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_hit_o <= 1'b0;
    end else begin
      prog_hit_o <= uid_hit; // [RL1]
    end
  end

  assign prog_rdata_o = uid_rdata;

  lrx_uid_store #(
    .COUNT(UID_CNT)
  ) u_uid (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .wr_i(uid_hit && prog_wr_i), // [RL1]
    .idx_i(prog_addr_i[$clog2(UID_CNT)-1:0]),
    .wdata_i(prog_wdata_i),
    .rdata_o(uid_rdata)
  );

  sequence s_ret_issue;
    take && (op == LRX_OP_LITRET || op == LRX_OP_RET);
  endsequence

  chk_ret_two_cycle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL4]
    s_ret_issue |=> busy_o && pc_load_o ##1 !busy_o) else $error("return not two cycles");
  chk_ret_pc_value: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL7]
    s_ret_issue |=> pc_o == $past(stack_top_entry_i) && stack_pop_o) else $error("pc not from stack");
  chk_litret_wreg: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL3]
    take && op == LRX_OP_LITRET |=> wreg_we_o && wreg_wdata_o == $past(lit) && !zero_we_o && !carry_we_o)
    else $error("literal return wrong");
  chk_rot_result: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL5]
    take && op == LRX_OP_ROT |=> carry_we_o && carry_o == $past(freg_rdata_i[MSB])
      && wreg_wdata_o == {$past(freg_rdata_i[MSB-1:0]), $past(carry_i)}) else $error("rotate wrong");
  chk_rot_dest: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL6]
    take && op == LRX_OP_ROT |=> freg_we_o == $past(dest) && wreg_we_o == !$past(dest))
    else $error("rotate destination wrong");
  chk_xorlit_res: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL8]
    take && op == LRX_OP_XORLIT |=> wreg_we_o && wreg_wdata_o == ($past(wreg_i) ^ $past(lit))
      && zero_we_o && !carry_we_o) else $error("xor literal wrong");
  chk_xorreg_dest: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL9]
    take && op == LRX_OP_XORREG |=> freg_we_o == $past(dest) && freg_wdata_o == ($past(wreg_i) ^ $past(freg_rdata_i)))
    else $error("xor register wrong");
  chk_zero_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL10]
    zero_we_o && wreg_we_o |-> zero_o == (wreg_wdata_o == '0)) else $error("zero flag wrong");
  chk_uid_nibble: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) // [RL2]
    prog_rdata_o[INSN_W-1:UID_W] == '0) else $error("uid upper bits set");
endmodule : lrx_exec

// File: tb/testbench.sv
// Self-checking bench for the executor and user ID store
`timescale 1ns/100ps
module testbench;
  import lrx_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic insn_valid_i = 1'b0;
  logic [13:0] insn_i = 14'h0;
  logic [7:0] wreg_i = 8'h0;
  logic [7:0] freg_rdata_i = 8'h0;
  logic carry_i = 1'b0;
  logic [13:0] stack_top_entry_i = 14'h0;
  logic prog_mode_i = 1'b0;
  logic prog_wr_i = 1'b0;
  logic [13:0] prog_addr_i = 14'h0;
  logic [13:0] prog_wdata_i = 14'h0;
  logic busy_o, wreg_we_o, freg_we_o, carry_we_o, carry_o, zero_we_o, zero_o, pc_load_o, stack_pop_o, prog_hit_o;
  logic [7:0] wreg_wdata_o, freg_wdata_o;
  logic [6:0] freg_addr_o;
  logic [13:0] pc_o, prog_rdata_o;
  logic [44:0] notes[$];
  logic [44:0] seen;
  logic [13:0] uid[4];
  logic [31:0] r;
  int fail_count = 0;
  int checks_done = 0;
  integer seed = 48;

  lrx_exec lrx_exec_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .insn_valid_i(insn_valid_i), .insn_i(insn_i),
    .busy_o(busy_o), .wreg_i(wreg_i), .freg_rdata_i(freg_rdata_i), .carry_i(carry_i),
    .stack_top_entry_i(stack_top_entry_i), .wreg_we_o(wreg_we_o), .wreg_wdata_o(wreg_wdata_o),
    .freg_we_o(freg_we_o), .freg_addr_o(freg_addr_o), .freg_wdata_o(freg_wdata_o), .carry_we_o(carry_we_o),
    .carry_o(carry_o), .zero_we_o(zero_we_o), .zero_o(zero_o), .pc_load_o(pc_load_o), .pc_o(pc_o),
    .stack_pop_o(stack_pop_o), .prog_mode_i(prog_mode_i), .prog_wr_i(prog_wr_i), .prog_addr_i(prog_addr_i),
    .prog_wdata_i(prog_wdata_i), .prog_rdata_o(prog_rdata_o), .prog_hit_o(prog_hit_o));

  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input string name, input logic [44:0] got, input logic [44:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  // Expected pulses, bit 45 set when the opcode gives a result
  function automatic logic [45:0] expect_of(input logic [13:0] i, input logic [7:0] w, input logic [7:0] f,
                                            input logic c, input logic [13:0] s);
    logic d;
    logic [7:0] x;
    d = i[7];
    x = (i[13:8] == 6'h0d) ? {f[6:0], c} : (i[13:8] == 6'h3a) ? w ^ i[7:0] : w ^ f;
    if (i[13:10] == 4'hd) expect_of = {2'b11, i[7:0], 20'h0, 1'b1, s, 1'b1};
    else if (i == 14'h0008) expect_of = {1'b1, 29'h0, 1'b1, s, 1'b1};
    else if (i[13:8] == 6'h0d) expect_of = {2'b10 | {1'b0, ~d}, ~d ? x : 8'h0, d, d ? i[6:0] : 7'h0,
                                            d ? x : 8'h0, 1'b1, f[7], 18'h0};
    else if (i[13:8] == 6'h3a) expect_of = {2'b11, x, 18'h0, 1'b1, x == 8'h0, 16'h0};
    else if (i[13:8] == 6'h06) expect_of = {2'b10 | {1'b0, ~d}, ~d ? x : 8'h0, d, d ? i[6:0] : 7'h0,
                                            d ? x : 8'h0, 3'b001, x == 8'h0, 16'h0};
    else expect_of = '0;
  endfunction : expect_of

  task automatic issue(input logic [13:0] i, input logic ign, input logic zw);
    logic [45:0] n;
    logic [7:0] w8;
    logic [7:0] f8;
    logic [13:0] s;
    logic c;
    w8 = zw ? i[7:0] : 8'($random(seed));
    f8 = zw ? w8 : 8'($random(seed));
    s = 14'($random(seed));
    c = 1'($random(seed));
    @(posedge clk_sys_i);
    insn_valid_i <= 1'b1;
    insn_i <= i;
    wreg_i <= w8;
    freg_rdata_i <= f8;
    carry_i <= c;
    stack_top_entry_i <= s;
    n = expect_of(i, w8, f8, c, s);
    if (!ign && n[45]) notes.push_back(n[44:0]);
    if (ign) @(negedge clk_sys_i) check("busy", 45'(busy_o), 45'h1);
  endtask : issue

  task automatic prog(input logic m, input logic wr, input logic [13:0] a, input logic [13:0] d,
                      input logic hit, input logic [13:0] rd);
    @(posedge clk_sys_i);
    prog_mode_i <= m;
    prog_wr_i <= wr;
    prog_addr_i <= a;
    prog_wdata_i <= d;
    @(posedge clk_sys_i);
    prog_wr_i <= 1'b0;
    @(negedge clk_sys_i);
    check("prog_hit", 45'(prog_hit_o), 45'(hit));
    if (hit && !wr) check("prog_rdata", 45'(prog_rdata_o), 45'(rd));
  endtask : prog

  // Scoreboard: oldest note against each result
  always @(negedge clk_sys_i) begin
    seen = {wreg_we_o, wreg_we_o ? wreg_wdata_o : 8'h0, freg_we_o, freg_we_o ? freg_addr_o : 7'h0,
            freg_we_o ? freg_wdata_o : 8'h0, carry_we_o, carry_we_o & carry_o, zero_we_o, zero_we_o & zero_o,
            pc_load_o, pc_load_o ? pc_o : 14'h0, stack_pop_o};
    if (rst_n_i && seen !== 45'h0) begin
      if (notes.size() == 0) check("spurious", seen, 45'h0);
      else begin
        check("writes", 45'(seen[44:20]), 45'(notes[0][44:20]));
        check("flags", 45'(seen[19:16]), 45'(notes[0][19:16]));
        check("pc", 45'(seen[15:0]), 45'(notes[0][15:0]));
        void'(notes.pop_front());
      end
    end
  end

  initial begin
    repeat (4000) @(posedge clk_sys_i);
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int n = 0; n < 60; n++) begin
      r = $random(seed);
      case (n % 6)
        0: issue({4'hd, r[9:0]}, 1'b0, 1'b0);
        1: issue(14'h0008, 1'b0, 1'b0);
        2: issue({6'h0d, r[7:0]}, 1'b0, 1'b0);
        3: issue({6'h3a, r[7:0]}, 1'b0, n[3]);
        4: issue({6'h06, r[7:0]}, 1'b0, n[3]);
        default: issue({6'h3f, r[7:0]}, 1'b0, 1'b0);
      endcase
      if (n % 6 < 2) issue({6'h3a, r[15:8]}, 1'b1, 1'b0);
    end
    @(posedge clk_sys_i);
    insn_valid_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    check("pending", 45'(notes.size()), 45'h0);
    prog(1'b1, 1'b0, 14'h2002, 14'h0, 1'b1, 14'h0);
    for (int k = 0; k < 4; k++) begin
      uid[k] = 14'($random(seed));
      prog(1'b1, 1'b1, 14'h2000 + 14'(k), uid[k], 1'b1, 14'h0);
      prog(1'b1, 1'b0, 14'h2000 + 14'(k), 14'h0, 1'b1, {10'h0, uid[k][3:0]});
    end
    prog(1'b0, 1'b1, 14'h2001, ~uid[1], 1'b0, 14'h0);
    prog(1'b1, 1'b1, 14'h2004, 14'h3fff, 1'b0, 14'h0);
    prog(1'b1, 1'b0, 14'h1fff, 14'h0, 1'b0, 14'h0);
    prog(1'b1, 1'b0, 14'h2001, 14'h0, 1'b1, {10'h0, uid[1][3:0]});
    prog(1'b1, 1'b0, 14'h2000, 14'h0, 1'b1, {10'h0, uid[0][3:0]});
    finish_test();
  end
endmodule : testbench
